/* acx_cfg.svh */
/*
  constants for the add-with-carry / and-literal execution unit.
  assumes inclusion by acx_core.sv only; acx_pkg.sv does not include it.
*/
`ifndef ACX_CFG_SVH
`define ACX_CFG_SVH
`define ACX_OP_ADDC 6'h08
`define ACX_OP_ANDL 8'h0B
`define ACX_TWO_WORD_PFX 4'hF
`define ACX_FAST_SPLIT 8'h5F
`define ACX_FAST_HIGH_PAGE 4'hF
`define ACX_FAST_LOW_PAGE 4'h0
`define ACX_FLAG_C 0
`define ACX_FLAG_DC 1
`define ACX_FLAG_Z 2
`define ACX_FLAG_OV 3
`define ACX_FLAG_N 4
`define ACX_FLAGS_RST 5'h00
`define ACX_ACCUM_RST 8'h00
`define ACX_BANK_RST 4'h0
`define ACX_OP_HI 15
`define ACX_OP_ADDC_LO 10
`define ACX_OP_ANDL_LO 8
`define ACX_PFX_LO 12
`define ACX_DEST_BIT 9
`define ACX_BANK_BIT 8
`define ACX_FILE_HI 7
`define ACX_INSTR_RST 16'h0000
`define ACX_DATA_RST 8'h00
`define ACX_ADDR_RST 12'h000
`define ACX_PIN_RST 1'b0
`endif

/* acx_pkg.sv */
/*
  types for the execution unit.
  assumes acx_cfg.svh is on the include path.
*/
package acx_pkg;
  typedef enum logic [1:0]
  {
    ACX_Q1_DECODE = 2'b00,
    ACX_Q2_READ = 2'b01,
    ACX_Q3_PROCESS = 2'b10,
    ACX_Q4_WRITE = 2'b11
  } acx_phase_e;
endpackage : acx_pkg

/* acx_core.sv */
/*
  execution unit: add-with-carry-to-file and and-literal-into-accumulator,
  with port read-modify-write, timer prescaler clear, idle-cycle handling.
  assumes program memory presents instruction_i steady for a whole cycle
  and data memory returns read data combinationally for file_addr_o.
*/
// Operation
// RQ1: port register read as its own source uses live pin levels, not latch.
// RQ2: writing back to first timer count clears its prescaler when assigned.
// RQ3: PC change or true test takes two cycles; second is idle.
// RQ4: lone second word of two-word instruction executes as idle.
// RQ5: add-with-carry sums accum, carry, file; updates N OV C DC Z.
// RQ6: destination bit 0 writes accumulator, 1 writes file register.
// RQ7: bank bit 0 selects fast page; 1 uses bank select register.
// RQ8: bank 0 with extended set and address <= 95 uses indexed offset.
// RQ9: and-literal ands accum with literal; updates only N and Z.
// RQ10: each instruction steps decode, read, process, write phases.
`timescale 1ns/1ps
`include "acx_cfg.svh"
module acx_core #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // program memory side
  input wire logic [15:0] instruction_i,
  input wire logic redirect_i,
  // configuration
  input wire logic extended_set_i,
  input wire logic prescaler_on_timer_i,
  input wire logic [3:0] bank_select_reg_i,
  input wire logic [ADDR_W-1:0] index_base_i,
  input wire logic [ADDR_W-1:0] first_timer_count_addr_i,
  input wire logic [ADDR_W-1:0] port_addr_lo_i,
  input wire logic [ADDR_W-1:0] port_addr_hi_i,
  // data memory and pins
  input wire logic [DATA_W-1:0] file_rdata_i,
  input wire logic [DATA_W-1:0] pin_level_i,
  output logic [ADDR_W-1:0] file_addr_o,
  output logic [DATA_W-1:0] file_wdata_o,
  output logic file_we_o,
  output logic file_re_o,
  // status
  output logic [DATA_W-1:0] accum_o,
  output logic [4:0] flags_o,
  output logic prescaler_clear_o,
  output logic idle_cycle_o,
  output logic [1:0] phase_o
);
  // opcode fields and page concatenations are laid out for these widths only
  if (DATA_W != 8 || ADDR_W != 12)
  begin : g_bad_width
    $error("acx_core supports only 8-bit data and 12-bit addresses");
  end

  // ==========================================================
  // phase sequencer
  acx_pkg::acx_phase_e phase_q;
  logic skip_q;
  logic [15:0] instr_q;
  logic [DATA_W-1:0] operand_q;
  logic [DATA_W-1:0] result_q;
  logic [4:0] flags_q;
  logic [DATA_W-1:0] accum_q;

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      phase_q <= acx_pkg::ACX_Q1_DECODE;
    else
    begin
      unique case (phase_q) // RQ10
        acx_pkg::ACX_Q1_DECODE: phase_q <= acx_pkg::ACX_Q2_READ;
        acx_pkg::ACX_Q2_READ: phase_q <= acx_pkg::ACX_Q3_PROCESS;
        acx_pkg::ACX_Q3_PROCESS: phase_q <= acx_pkg::ACX_Q4_WRITE;
        acx_pkg::ACX_Q4_WRITE: phase_q <= acx_pkg::ACX_Q1_DECODE;
      endcase
    end
  end

  // ==========================================================
  // decode
  logic is_addc;
  logic is_andl;
  logic is_second_word;
  logic dest_file;
  logic bank_bit;
  logic [7:0] faddr;
  logic idle;

  assign is_addc = instr_q[`ACX_OP_HI:`ACX_OP_ADDC_LO] == `ACX_OP_ADDC;
  assign is_andl = instr_q[`ACX_OP_HI:`ACX_OP_ANDL_LO] == `ACX_OP_ANDL;
  assign is_second_word = instr_q[`ACX_OP_HI:`ACX_PFX_LO] == `ACX_TWO_WORD_PFX; // RQ4
  assign dest_file = instr_q[`ACX_DEST_BIT]; // RQ6
  assign bank_bit = instr_q[`ACX_BANK_BIT];
  assign faddr = instr_q[`ACX_FILE_HI:0];
  // flushed slot and lone second word both run as idle cycles
  assign idle = skip_q || is_second_word || !(is_addc || is_andl); // RQ3 RQ4

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      instr_q <= `ACX_INSTR_RST;
    else if (phase_q == acx_pkg::ACX_Q1_DECODE)
      instr_q <= instruction_i;
  end

  // a redirect flushes the next fetched word so it executes as idle
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      skip_q <= 1'b0;
    else if (phase_q == acx_pkg::ACX_Q4_WRITE)
      skip_q <= redirect_i; // RQ3
  end

  // ==========================================================
  // file address formation
  logic [ADDR_W-1:0] eff_addr;

  always_comb
  begin
    if (bank_bit)
      eff_addr = {bank_select_reg_i, faddr}; // RQ7
    else if (extended_set_i && faddr <= `ACX_FAST_SPLIT)
      eff_addr = ADDR_W'(index_base_i + {4'h0, faddr}); // RQ8
    else if (faddr <= `ACX_FAST_SPLIT)
      eff_addr = {`ACX_FAST_LOW_PAGE, faddr}; // RQ7
    else
      eff_addr = {`ACX_FAST_HIGH_PAGE, faddr}; // RQ7
  end

  // ==========================================================
  // pin level synchroniser
  // pins are asynchronous: three stages per bit, and a level is taken
  // only once stages two and three agree, so a bit caught mid-change
  // never reaches the adder
  logic [DATA_W-1:0] pin_live;

  for (genvar b = 0; b < DATA_W; b++)
  begin : g_pin_sync
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic live_q;

    always_ff @(posedge clock_i)
    begin
      if (reset_i)
      begin
        s1_q <= `ACX_PIN_RST;
        s2_q <= `ACX_PIN_RST;
        s3_q <= `ACX_PIN_RST;
        live_q <= `ACX_PIN_RST;
      end
      else
      begin
        s1_q <= pin_level_i[b];
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q)
          live_q <= s3_q; // RQ1
      end
    end

    assign pin_live[b] = live_q;
  end

  logic is_port;
  assign is_port = eff_addr >= port_addr_lo_i && eff_addr <= port_addr_hi_i;

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      operand_q <= `ACX_DATA_RST;
    else if (phase_q == acx_pkg::ACX_Q2_READ)
      operand_q <= is_addc ? (is_port ? pin_live : file_rdata_i) // RQ1
                           : faddr;
  end

  // ==========================================================
  // arithmetic
  logic [8:0] sum;
  logic [4:0] low_sum;
  logic [DATA_W-1:0] res;
  logic [4:0] nflags;

  always_comb
  begin
    sum = {1'b0, accum_q} + {1'b0, operand_q} + {8'h00, flags_q[`ACX_FLAG_C]}; // RQ5
    low_sum = {1'b0, accum_q[3:0]} + {1'b0, operand_q[3:0]}
            + {4'h0, flags_q[`ACX_FLAG_C]};
    nflags = flags_q;
    if (is_addc)
    begin
      res = sum[7:0];
      nflags[`ACX_FLAG_C] = sum[8]; // RQ5
      nflags[`ACX_FLAG_DC] = low_sum[4];
      nflags[`ACX_FLAG_OV] = (accum_q[7] == operand_q[7]) && (res[7] != accum_q[7]);
    end
    else
      res = accum_q & operand_q; // RQ9
    nflags[`ACX_FLAG_Z] = res == 8'h00;
    nflags[`ACX_FLAG_N] = res[7];
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      result_q <= `ACX_DATA_RST;
    else if (phase_q == acx_pkg::ACX_Q3_PROCESS)
      result_q <= res;
  end

  // ==========================================================
  // write back
  logic do_write;
  assign do_write = phase_q == acx_pkg::ACX_Q4_WRITE && !idle;

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      accum_q <= `ACX_ACCUM_RST;
    else if (do_write && (is_andl || !dest_file))
      accum_q <= result_q; // RQ6 RQ9
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      flags_q <= `ACX_FLAGS_RST;
    else if (phase_q == acx_pkg::ACX_Q3_PROCESS && !idle)
      flags_q <= nflags; // RQ5 RQ9
  end

  // file port outputs
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic we_q;
  logic re_q;
  logic psc_q;

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      addr_q <= `ACX_ADDR_RST;
      wdata_q <= `ACX_DATA_RST;
      we_q <= 1'b0;
      re_q <= 1'b0;
      psc_q <= 1'b0;
    end
    else
    begin
      addr_q <= eff_addr;
      wdata_q <= res;
      re_q <= phase_q == acx_pkg::ACX_Q1_DECODE;
      we_q <= phase_q == acx_pkg::ACX_Q3_PROCESS && !idle && is_addc && dest_file; // RQ6
      psc_q <= phase_q == acx_pkg::ACX_Q3_PROCESS && !idle && is_addc && dest_file
               && eff_addr == first_timer_count_addr_i && prescaler_on_timer_i; // RQ2
    end
  end

  assign file_addr_o = is_addc ? eff_addr : addr_q;
  assign file_wdata_o = wdata_q;
  assign file_we_o = we_q && is_addc;
  assign file_re_o = re_q && is_addc && !idle;
  assign accum_o = accum_q;
  assign flags_o = flags_q;
  assign prescaler_clear_o = psc_q;
  assign idle_cycle_o = idle;
  assign phase_o = phase_q;
endmodule : acx_core

/* acx_core_sva.sv */
/* checker for acx_core ports: phases, strobes, idle cycles.
   bound into acx_core; one clock domain. */
`timescale 1ns/1ps
module acx_core_sva (
  // watched ports
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic redirect_i,
  input wire logic prescaler_on_timer_i,
  input wire logic [11:0] first_timer_count_addr_i,
  input wire logic [11:0] file_addr_o,
  input wire logic file_we_o,
  input wire logic file_re_o,
  input wire logic [7:0] accum_o,
  input wire logic [4:0] flags_o,
  input wire logic prescaler_clear_o,
  input wire logic idle_cycle_o,
  input wire logic [1:0] phase_o
);
  // ==========
  // properties
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  phase_step_a: assert property (1'b1 |=> phase_o == 2'($past(phase_o) + 2'd1))
    else $error("phase order");
  re_phase_a: assert property (file_re_o |-> phase_o == 2'd1)
    else $error("read phase");
  we_phase_a: assert property (file_we_o |-> phase_o == 2'd3 && !idle_cycle_o)
    else $error("write phase");
  clr_cause_a: assert property (prescaler_clear_o |-> file_we_o && prescaler_on_timer_i
    && file_addr_o == first_timer_count_addr_i) else $error("prescaler clear");
  redir_idle_a: assert property (phase_o == 2'd3 && redirect_i |-> ##2 idle_cycle_o[*3])
    else $error("redirect idle");
  idle_quiet_a: assert property (idle_cycle_o |=> $stable(flags_o) && $stable(accum_o))
    else $error("idle changed state");
  accum_when_a: assert property ($changed(accum_o) |-> $past(phase_o) == 2'd3)
    else $error("accumulator timing");
  flags_when_a: assert property ($changed(flags_o) |-> $past(phase_o) == 2'd2)
    else $error("flag timing");
  cover property (prescaler_clear_o);
  cover property (file_we_o);
  cover property (phase_o == 2'd3 && redirect_i);
endmodule : acx_core_sva
bind acx_core acx_core_sva sva_u (.*);

/* acx_dmem_model.sv */
/* data memory facing acx_core.
   assumes reads are combinational and writes land at the rising edge. */
`timescale 1ns/1ps
module acx_dmem_model (
  // core side
  input wire logic clock_i,
  input wire logic [11:0] file_addr_i,
  input wire logic [7:0] file_wdata_i,
  input wire logic file_we_i,
  input wire logic file_re_i,
  output logic [7:0] file_rdata_o
);
  // ==========
  // storage
  logic [7:0] mem [4096];
  logic tick_q = 1'b0;
  // bus toggles outside reads so a stale operand cannot pass
  assign file_rdata_o = file_re_i ? mem[file_addr_i] : {4{tick_q, !tick_q}};
  // plain always: the bench preloads mem through the hierarchy
  always @(posedge clock_i)
  begin
    tick_q <= !tick_q;
    if (file_we_i)
      mem[file_addr_i] <= file_wdata_i;
  end
endmodule : acx_dmem_model

/* acx_core_tb_top.sv */
/* self-checking bench for acx_core.
   assumes acx_core_sva.sv binds the checker. */
`timescale 1ns/1ps
module acx_core_tb_top;
  // ==========
  // signals
  typedef struct packed {logic [15:0] w; logic [7:0] acc; logic [4:0] flg;} acx_row_s;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic [15:0] instruction_i = 16'h0000;
  logic redirect_i = 1'b0;
  logic extended_set_i = 1'b0;
  logic prescaler_on_timer_i = 1'b1;
  logic [7:0] pin_level_i = 8'h0F;
  logic [7:0] file_rdata_i, file_wdata_o, accum_o;
  logic [11:0] file_addr_o;
  logic file_we_o, file_re_o, prescaler_clear_o, idle_cycle_o;
  logic [4:0] flags_o;
  logic [1:0] phase_o;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  int clr_n = 0;
  acx_row_s rows [7] = '{
    '{16'h2110, 8'h4D, 5'h00}, '{16'h2111, 8'h02, 5'h03}, '{16'h2312, 8'h02, 5'h1A},
    '{16'h0B5F, 8'h02, 5'h0A}, '{16'h0B00, 8'h00, 5'h0E}, '{16'h2020, 8'hFF, 5'h10},
    '{16'h2060, 8'h00, 5'h07}};
  acx_core dut_u (.*, .bank_select_reg_i(4'h3), .index_base_i(12'h100),
    .first_timer_count_addr_i(12'hFD6), .port_addr_lo_i(12'hF80), .port_addr_hi_i(12'hF84));
  acx_dmem_model mem_u (.clock_i(clock_i), .file_addr_i(file_addr_o),
    .file_wdata_i(file_wdata_o), .file_we_i(file_we_o), .file_re_i(file_re_o),
    .file_rdata_o(file_rdata_i));
  always #12.5 clock_i = !clock_i;
  always @(negedge clock_i)
    if (prescaler_clear_o === 1'b1)
      clr_n++;
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      bad_count++;
      test_done();
    end
  end
  task automatic chk(string n, logic [11:0] e, logic [11:0] s);
    check_count++;
    if (e !== s)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic exec(logic [15:0] w, logic rd);
    do @(negedge clock_i); while (phase_o !== 2'd3);
    @(posedge clock_i);
    instruction_i <= w;
    redirect_i <= rd;
  endtask : exec
  // an idle word after each case lets its result land before it is read
  task automatic step(logic [15:0] w, logic [7:0] acc, logic [4:0] flg);
    exec(w, 1'b0);
    exec(16'h0000, 1'b0);
    @(negedge clock_i);
    chk("accum", {4'h0, acc}, {4'h0, accum_o});
    chk("flags", {7'h00, flg}, {7'h00, flags_o});
  endtask : step
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done
  initial
  begin
    mem_u.mem[12'h310] = 8'h4D;
    mem_u.mem[12'h311] = 8'hB5;
    mem_u.mem[12'h312] = 8'h7F;
    mem_u.mem[12'h020] = 8'hFF;
    mem_u.mem[12'hF60] = 8'h01;
    mem_u.mem[12'hF82] = 8'hF0;
    mem_u.mem[12'hFD6] = 8'h00;
    mem_u.mem[12'h105] = 8'h11;
    repeat (10) @(posedge clock_i);
    reset_i <= 1'b0;
    foreach (rows[i]) step(rows[i].w, rows[i].acc, rows[i].flg);
    chk("file", 12'h082, {4'h0, mem_u.mem[12'h312]});
    $display("table done");
    step(16'h2282, 8'h00, 5'h02);
    chk("port", 12'h010, {4'h0, mem_u.mem[12'hF82]});
    step(16'h22D6, 8'h00, 5'h04);
    @(posedge clock_i);
    prescaler_on_timer_i <= 1'b0;
    step(16'h22D6, 8'h00, 5'h04);
    chk("clears", 12'd1, 12'(clr_n));
    $display("port and timer done");
    @(posedge clock_i);
    extended_set_i <= 1'b1;
    step(16'h2005, 8'h11, 5'h00);
    @(posedge clock_i);
    reset_i <= 1'b1;
    repeat (10) @(negedge clock_i);
    chk("reset accum", 12'h000, {4'h0, accum_o});
    chk("reset phase", 12'h000, {10'h000, phase_o});
    chk("reset flags", 12'h000, {7'h00, flags_o});
    $display("extended and reset done");
    @(posedge clock_i);
    reset_i <= 1'b0;
    exec(16'h0B00, 1'b1);
    exec(16'h2005, 1'b0);
    repeat (2) @(negedge clock_i);
    chk("idle skip", 12'h001, {11'h000, idle_cycle_o});
    exec(16'hF105, 1'b0);
    repeat (2) @(negedge clock_i);
    chk("idle word", 12'h001, {11'h000, idle_cycle_o});
    step(16'h0000, 8'h00, 5'h04);
    $display("idle done");
    test_done();
  end
endmodule : acx_core_tb_top
